// ### dv/bus_host.sv
// bus master standing in for the instruction sequencer
`timescale 1ns/1ns
`default_nettype none
module bus_host (
    // clock
    input wire logic clk,
    // write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    output logic bready,
    // read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // idle from time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // one write; released lines are scrambled, not left showing
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw, w;
        begin
            @(posedge clk);
            {aw, w} = 2'b11;
            {awaddr, wdata} <= {a, d};
            {awvalid, wvalid, bready, wstrb} <= 7'h7f;
            while (aw || w) begin
                @(posedge clk);
                if (aw && awready) begin
                    aw = 1'b0;
                    {awvalid, awaddr} <= {1'b0, ~a};
                end
                if (w && wready) begin
                    w = 1'b0;
                    {wvalid, wdata} <= {1'b0, ~d};
                end
            end
            while (!bvalid) @(posedge clk);
            r = bresp;
            bready <= 1'b0;
        end
    endtask
    // one read, ready held until data seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        begin
            @(posedge clk);
            {araddr, arvalid, rready} <= {a, 2'b11};
            do @(posedge clk); while (!arready);
            {arvalid, araddr} <= {1'b0, ~a};
            while (!rvalid) @(posedge clk);
            {d, r} = {rdata, rresp};
            rready <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### dv/converter_checker.sv
// port assertions for the converter register slave
`timescale 1ns/1ns
`default_nettype none
module converter_checker (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // write channels
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic [1:0] BRESP,
    input wire logic BREADY,
    // read channels
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY
);
    // ----------------------------------------
    // handshake steps
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // both halves of a fresh write taken at one edge
    sequence wr_take;
        AWVALID && AWREADY && WVALID && WREADY && !BVALID;
    endsequence
    sequence rd_take;
        ARVALID && ARREADY;
    endsequence
    chk_aw_closes: assert property (AWVALID && AWREADY |=> !AWREADY)
        else $error("address ready high after take");
    chk_w_closes: assert property (WVALID && WREADY |=> !WREADY)
        else $error("data ready high after take");
    chk_b_answer: assert property (wr_take |-> ##2 BVALID)
        else $error("write response late");
    chk_b_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    chk_r_answer: assert property (rd_take |=> RVALID)
        else $error("read data late");
    chk_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    chk_ar_blocked: assert property (RVALID |-> !ARREADY)
        else $error("read address open while data pending");
    chk_err_blank: assert property (RVALID && RRESP == 2'h2 |-> RDATA == 32'h0)
        else $error("refused read carries data");
endmodule
bind number_format_converter converter_checker chk_i (.CLOCK, .RST,
    .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BRESP, .BREADY,
    .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
`default_nettype wire

// ### dv/tb_number_format_converter.sv
// self-checking bench for the number-format converter
`timescale 1ns/1ns
`default_nettype none
`include "converter_map.vh"
module tb_number_format_converter;
    logic clock, rst, irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, m_dst;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] m_err;
    int err_total, checks_done, i;
    number_format_converter DUT (.CLOCK(clock), .RST(rst),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BVALID(bvalid), .BRESP(bresp), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .IRQ(irq));
    bus_host h (.clk(clock), .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bvalid, .bresp, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    // 10 MHz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // model: binary to packed digits, eight nibbles
    function automatic logic [31:0] bcd(input logic [31:0] v);
        for (int k = 0; k < 8; k++) begin
            bcd[4*k +: 4] = 4'(v % 10);
            v = v / 10;
        end
    endfunction
    function automatic logic [31:0] unbcd(input logic [31:0] x, input int n,
                                          output logic bad);
        {unbcd, bad} = '0;
        for (int k = n - 1; k >= 0; k--) begin
            bad |= x[4*k +: 4] > 4'h9;
            unbcd = unbcd * 10 + x[4*k +: 4];
        end
    endfunction
    // model float: truncation toward zero, as chosen
    function automatic logic [31:0] integer_to_single_float(input longint v);
        longint m;
        int p;
        if (v == 0) return 32'h0;
        m = v < 0 ? -v : v;
        p = 0;
        while ((m >> (p + 1)) != 0) p++;
        m = p > 23 ? m >> (p - 23) : m << (23 - p);
        return {v < 0, 8'(127 + p), m[22:0]};
    endfunction
    // one pulse-mode conversion, then all results read back
    task automatic run(input logic [2:0] op, input logic cnt,
                       input logic [15:0] lo, hi);
        logic [31:0] v, x;
        logic bad, z;
        logic [15:0] c;
        v = {hi, lo};
        x = m_dst;
        c = 16'h0;
        case (op)
            3'h0: if (cnt) c = `ERR_OPERAND;
                else if (lo > `BCD16_MAX) c = `ERR_BAD_DIGIT;
                else x = bcd({16'h0, lo});
            3'h1: if (v > `BCD32_MAX) c = `ERR_BAD_DIGIT;
                else x = bcd(v);
            3'h2: begin
                x = unbcd({16'h0, lo}, 4, bad);
                if (cnt) c = `ERR_OPERAND;
                else if (bad) c = `ERR_BAD_DIGIT;
            end
            3'h3: begin
                x = unbcd(v, 8, bad);
                if (bad) c = `ERR_BAD_DIGIT;
            end
            3'h4: if (cnt) c = `ERR_OPERAND;
                else x = integer_to_single_float($signed(lo));
            3'h5: x = integer_to_single_float($signed(v));
            default: ;
        endcase
        if (op == 3'h0 || op == 3'h2) x[31:16] = m_dst[31:16];
        if (c != 16'h0) {x, m_err} = {m_dst, c};
        z = op[2:1] == 2'b10 && c == 16'h0 && x == 32'h0;
        m_dst = x;
        h.wr(`OFF_SRC_LO, {16'h0, lo}, r);
        h.wr(`OFF_SRC_HI, {16'h0, hi}, r);
        h.wr(`OFF_STATUS, 32'h1f, r);
        h.wr(`OFF_CTRL, {26'h0, cnt, 2'b11, op}, r);
        h.wr(`OFF_CTRL, 32'h0, r);
        h.rd(`OFF_DST_LO, d, r);
        chk("dst_lo", {16'h0, m_dst[15:0]}, d);
        h.rd(`OFF_DST_HI, d, r);
        chk("dst_hi", {16'h0, m_dst[31:16]}, d);
        h.rd(`OFF_ERR_CODE, d, r);
        chk("err_code", {16'h0, m_err}, d);
        h.rd(`OFF_STATUS, d, r);
        chk("status", {27'h1, 2'b0, z, c != 16'h0}, d);
    endtask
    // watchdog, far beyond the expected run length
    initial begin
        #5000000;
        err_total++;
        stop_test;
    end
    initial begin
        {err_total, checks_done, m_dst, m_err, rst} = '1;
        {err_total, checks_done, m_dst, m_err} = '0;
        void'($urandom(32'hd84b30d9));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            h.rd(8'(4 * i), d, r);
            chk("reset value", 32'h0, {d[31:2], d[1:0] | r});
        end
        run(0, 0, 16'd9999, 0);
        run(0, 0, 16'd10000, 0);
        run(1, 0, 16'he0ff, 16'h05f5);
        run(1, 0, 16'he100, 16'h05f5);
        run(2, 0, 16'h9999, 0);
        run(2, 0, 16'h12a4, 0);
        run(3, 1, 16'h9999, 16'h9999);
        run(3, 0, 16'h0000, 16'ha000);
        run(0, 1, 16'd12, 0);
        run(2, 1, 16'h12, 0);
        run(4, 1, 16'd10, 0);
        run(4, 0, 16'd10, 0);
        run(4, 0, 16'h0, 0);
        run(4, 0, 16'h8000, 0);
        run(5, 1, 16'h86a0, 16'h0001);
        run(5, 0, 16'hffff, 16'h7fff);
        run(6, 0, 16'h5, 0);
        for (i = 0; i < 10; i++) begin
            run(3'($urandom % 6), 1'($urandom), 16'($urandom), 16'($urandom));
        end
        // interrupt: masked, unmasked, cleared
        chk("irq masked", 1'b0, irq);
        h.wr(`OFF_MASK, 32'h10, r);
        repeat (2) @(posedge clock);
        chk("irq raised", 1'b1, irq);
        h.wr(`OFF_STATUS, 32'h10, r);
        repeat (2) @(posedge clock);
        chk("irq cleared", 1'b0, irq);
        // pulse runs once, level keeps following the source
        h.wr(`OFF_SRC_LO, 32'd10, r);
        h.wr(`OFF_CTRL, 32'h1c, r);
        h.wr(`OFF_SRC_LO, 32'd5, r);
        h.rd(`OFF_DST_HI, d, r);
        chk("pulse once", 32'h4120, d);
        h.wr(`OFF_CTRL, 32'h14, r);
        h.wr(`OFF_SRC_LO, 32'd3, r);
        h.rd(`OFF_DST_HI, d, r);
        chk("level runs", 32'h4040, d);
        h.wr(`OFF_CTRL, 32'h0, r);
        m_dst = 32'h40400000;
        // unmapped and read-only places
        h.wr(8'h20, 32'h1, r);
        chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, r});
        h.rd(8'h24, d, r);
        chk("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, r});
        h.wr(`OFF_ERR_CODE, 32'h1234, r);
        h.rd(`OFF_ERR_CODE, d, r);
        chk("err_code kept", {16'h0, m_err}, d);
        stop_test;
    end
endmodule
`default_nettype wire

// ### rtl/converter_map.vh
// constants for the number-format conversion datapath
//
// Notes on behaviour
// - binary to packed decimal into destination
// - 16-bit over 9999: keep destination, flag error
// - 32-bit over 99999999: abort, flag error
// - packed decimal nibbles converted to binary
// - counter operand only for 32-bit decimal and 32-bit float forms
// - nibble above nine flags error code
// - signed integer converted to single float
// - counter never source of 16-bit float
// - float forms read one or two words
// - too large: overflow flag, maximum float
// - too small: underflow flag, minimum float
// - zero float result sets zero flag
`ifndef CONVERTER_MAP_VH
`define CONVERTER_MAP_VH

// ----------
// register byte offsets
// ----------
`define OFF_CTRL 8'h00
`define OFF_SRC_LO 8'h04
`define OFF_SRC_HI 8'h08
`define OFF_DST_LO 8'h0c
`define OFF_DST_HI 8'h10
`define OFF_ERR_CODE 8'h14
`define OFF_STATUS 8'h18
`define OFF_MASK 8'h1c

// ----------
// control fields
// ----------
`define CTRL_OP_HI 2
`define CTRL_OP_LO 0
`define CTRL_PULSE 3
`define CTRL_COND 4
`define CTRL_COUNTER 5
`define CTRL_W 6
`define CTRL_RST 6'h00

// ----------
// operation codes
// ----------
`define OP_TO_BCD16 3'h0
`define OP_TO_BCD32 3'h1
`define OP_FROM_BCD16 3'h2
`define OP_FROM_BCD32 3'h3
`define OP_FLT16 3'h4
`define OP_FLT32 3'h5

// ----------
// status and mask bits
// ----------
`define ST_OP_ERROR 0
`define ST_ZERO 1
`define ST_UNDERFLOW 2
`define ST_OVERFLOW 3
`define ST_DONE 4
`define ST_W 5
`define ST_RST 5'h00

// ----------
// error codes, limits, float constants
// ----------
`define ERR_BAD_DIGIT 16'h200d
`define ERR_OPERAND 16'h2003
`define BCD16_MAX 16'h270f
`define BCD32_MAX 32'h05f5e0ff
`define FLT_BIAS 9'h07f
`define FLT_EXP_MAX 9'h0fe
`define FLT_MAX_MAG 31'h7f7fffff
`define FLT_MIN_MAG 31'h00800000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/int_to_float.v
// signed 32-bit integer to single-precision float, combinational
`timescale 1ns/1ns
`default_nettype none
`include "converter_map.vh"

module int_to_float (
    // integer in
    input wire [31:0] value,
    // float out with flags
    output reg [31:0] result,
    output reg zero,
    output reg overflow,
    output reg underflow
);

    reg [31:0] mag; // absolute value
    reg [31:0] norm; // magnitude with leading one at top
    reg [4:0] msb; // position of leading one
    reg [8:0] exp9; // biased exponent, one spare bit
    integer i;

    // ------------------------------------------------------------
    // normalise, truncate toward zero, saturate
    // ------------------------------------------------------------
    always @* begin
        mag = value[31] ? (~value + 32'h00000001) : value;
        msb = 5'h00;
        for (i = 0; i < 32; i = i + 1) begin
            if (mag[i]) begin
                msb = i[4:0];
            end
        end
        norm = mag << (5'h1f - msb);
        exp9 = {4'h0, msb} + `FLT_BIAS;
        zero = (mag == 32'h00000000);
        // an integer source never reaches these limits; the guards
        // keep saturation correct if the datapath is ever widened
        overflow = exp9 > `FLT_EXP_MAX;
        underflow = !zero && (exp9 == 9'h000);
        if (zero) begin
            result = 32'h00000000;
        end else if (overflow) begin
            result = {value[31], `FLT_MAX_MAG};
        end else if (underflow) begin
            result = {value[31], `FLT_MIN_MAG};
        end else begin
            result = {value[31], exp9[7:0], norm[30:8]};
        end
    end

endmodule
`default_nettype wire

// ### rtl/number_format_converter.v
// number-format conversion datapath with axi4-lite register slave
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "converter_map.vh"

module number_format_converter (
    // clock and reset
    input wire CLOCK,
    input wire RST,
    // write address channel
    input wire [7:0] AWADDR,
    input wire AWVALID,
    output wire AWREADY,
    // write data channel
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    input wire WVALID,
    output wire WREADY,
    // write response channel
    output wire BVALID,
    output wire [1:0] BRESP,
    input wire BREADY,
    // read address channel
    input wire [7:0] ARADDR,
    input wire ARVALID,
    output wire ARREADY,
    // read data channel
    output wire [31:0] RDATA,
    output wire [1:0] RRESP,
    output wire RVALID,
    input wire RREADY,
    // interrupt
    output wire IRQ
);

    // ----------
    // bus-side state
    // ----------
    reg awready_reg; // low while an address is held
    reg wready_reg; // low while data is held
    reg bvalid_reg; // write answer pending
    reg [1:0] bresp_reg; // write answer code
    reg arready_reg; // low while a read answer is out
    reg rvalid_reg; // read answer pending
    reg [31:0] rdata_reg; // read answer data
    reg [1:0] rresp_reg; // read answer code
    reg [7:0] awaddr_reg; // held write address
    reg [31:0] wdata_reg; // held write data
    reg [3:0] wstrb_reg; // held byte enables

    // ----------
    // programmer-visible registers
    // ----------
    reg [`CTRL_W-1:0] ctrl_reg; // op, pulse, issue, counter
    reg [15:0] src_lo_reg; // source low word
    reg [15:0] src_hi_reg; // source high word
    reg [15:0] dst_lo_reg; // destination low word
    reg [15:0] dst_hi_reg; // destination high word
    reg [15:0] err_code_reg; // last error code
    reg [`ST_W-1:0] status_reg; // sticky event flags
    reg [`ST_W-1:0] mask_reg; // interrupt enables
    reg cond_d_reg; // issue condition, one cycle late
    reg irq_reg; // registered interrupt level

    // ----------
    // outputs straight from flops
    // ----------
    assign AWREADY = awready_reg;
    assign WREADY = wready_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign ARREADY = arready_reg;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;
    assign IRQ = irq_reg;

    // ----------
    // packed decimal helpers
    // ----------

    // binary to eight packed digits by shift and add-three
    function [31:0] bin2bcd;
        input [31:0] v;
        reg [31:0] b;
        integer k;
        integer d;
        begin
            b = 32'h00000000;
            for (k = 31; k >= 0; k = k - 1) begin
                for (d = 0; d < 8; d = d + 1) begin
                    if (b[d*4 +: 4] > 4'h4) begin
                        b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
                    end
                end
                b = {b[30:0], v[k]};
            end
            bin2bcd = b;
        end
    endfunction

    // eight packed digits to binary, top digit first
    function [31:0] bcd2bin;
        input [31:0] v;
        reg [31:0] acc;
        integer k;
        begin
            acc = 32'h00000000;
            for (k = 7; k >= 0; k = k - 1) begin
                acc = (acc << 3) + (acc << 1) + {28'h0, v[k*4 +: 4]};
            end
            bcd2bin = acc;
        end
    endfunction

    // any nibble above nine
    function bad_digit;
        input [31:0] v;
        integer k;
        begin
            bad_digit = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (v[k*4 +: 4] > 4'h9) begin
                    bad_digit = 1'b1;
                end
            end
        end
    endfunction

    // ----------
    // operand selection and converters
    // ----------
    wire [2:0] op = ctrl_reg[`CTRL_OP_HI:`CTRL_OP_LO];
    wire cond = ctrl_reg[`CTRL_COND];
    wire is_counter = ctrl_reg[`CTRL_COUNTER];
    wire [31:0] src32 = {src_hi_reg, src_lo_reg};
    wire wide = (op == `OP_TO_BCD32) || (op == `OP_FROM_BCD32);
    wire [31:0] dec_in = wide ? src32 : {16'h0000, src_lo_reg};
    wire [31:0] bcd_w = bin2bcd(dec_in);
    wire [31:0] bin_w = bcd2bin(dec_in);
    wire bad_w = bad_digit(dec_in);
    // one source word sign-extended, or the word pair
    wire [31:0] flt_in = (op == `OP_FLT32) ? src32 :
        {{16{src_lo_reg[15]}}, src_lo_reg};
    wire [31:0] flt_w;
    wire flt_zero;
    wire flt_over;
    wire flt_under;

    int_to_float u_flt (
        .value(flt_in),
        .result(flt_w),
        .zero(flt_zero),
        .overflow(flt_over),
        .underflow(flt_under)
    );

    // ----------
    // issue: level form every cycle, pulse form on the rising edge
    // ----------
    wire exec = cond && (!ctrl_reg[`CTRL_PULSE] || !cond_d_reg);

    // ----------
    // conversion result and flag selection
    // ----------
    reg wr_lo; // write destination low word
    reg wr_hi; // write destination high word
    reg [15:0] res_lo; // new low word
    reg [15:0] res_hi; // new high word
    reg err_load; // load error code, raise error flag
    reg [15:0] err_val; // code to load
    reg [`ST_W-1:0] ev; // events of this execution

    always @* begin
        wr_lo = 1'b0;
        wr_hi = 1'b0;
        res_lo = 16'h0000;
        res_hi = 16'h0000;
        err_load = 1'b0;
        err_val = `ERR_BAD_DIGIT;
        ev = `ST_RST;
        case (op)
            `OP_TO_BCD16: begin
                if (is_counter) begin
                    err_load = 1'b1;
                    err_val = `ERR_OPERAND;
                end else if (src_lo_reg > `BCD16_MAX) begin
                    err_load = 1'b1;
                end else begin
                    wr_lo = 1'b1;
                    res_lo = bcd_w[15:0];
                end
            end
            `OP_TO_BCD32: begin
                // unsigned compare also rejects negative values
                if (src32 > `BCD32_MAX) begin
                    err_load = 1'b1;
                end else begin
                    wr_lo = 1'b1;
                    wr_hi = 1'b1;
                    res_lo = bcd_w[15:0];
                    res_hi = bcd_w[31:16];
                end
            end
            `OP_FROM_BCD16: begin
                if (is_counter) begin
                    err_load = 1'b1;
                    err_val = `ERR_OPERAND;
                end else if (bad_w) begin
                    err_load = 1'b1;
                end else begin
                    wr_lo = 1'b1;
                    res_lo = bin_w[15:0];
                end
            end
            `OP_FROM_BCD32: begin
                // eight valid digits always fit; range kept by program
                if (bad_w) begin
                    err_load = 1'b1;
                end else begin
                    wr_lo = 1'b1;
                    wr_hi = 1'b1;
                    res_lo = bin_w[15:0];
                    res_hi = bin_w[31:16];
                end
            end
            `OP_FLT16, `OP_FLT32: begin
                if (is_counter && (op == `OP_FLT16)) begin
                    err_load = 1'b1;
                    err_val = `ERR_OPERAND;
                end else begin
                    wr_lo = 1'b1;
                    wr_hi = 1'b1;
                    res_lo = flt_w[15:0];
                    res_hi = flt_w[31:16];
                    ev[`ST_ZERO] = flt_zero;
                    ev[`ST_UNDERFLOW] = flt_under;
                    ev[`ST_OVERFLOW] = flt_over;
                end
            end
            default: begin
                // unused codes run as no operation
                wr_lo = 1'b0;
            end
        endcase
        ev[`ST_OP_ERROR] = err_load;
        ev[`ST_DONE] = 1'b1;
    end

    // ----------
    // write decode
    // ----------
    wire do_write = !awready_reg && !wready_reg && !bvalid_reg;
    wire [7:0] wa = awaddr_reg;
    wire w_ctrl = do_write && (wa == `OFF_CTRL);
    wire w_src_lo = do_write && (wa == `OFF_SRC_LO);
    wire w_src_hi = do_write && (wa == `OFF_SRC_HI);
    wire w_status = do_write && (wa == `OFF_STATUS);
    wire w_mask = do_write && (wa == `OFF_MASK);
    // read-only words answer okay and ignore data
    wire w_known = (wa == `OFF_CTRL) || (wa == `OFF_SRC_LO) ||
        (wa == `OFF_SRC_HI) || (wa == `OFF_DST_LO) ||
        (wa == `OFF_DST_HI) || (wa == `OFF_ERR_CODE) ||
        (wa == `OFF_STATUS) || (wa == `OFF_MASK);

    // write-one-to-clear; a new event wins over the clear
    wire [`ST_W-1:0] st_clr = (w_status && wstrb_reg[0]) ?
        wdata_reg[`ST_W-1:0] : `ST_RST;
    wire [`ST_W-1:0] st_set = exec ? ev : `ST_RST;
    wire [`ST_W-1:0] status_next = (status_reg & ~st_clr) | st_set;

    // ----------
    // axi4-lite write channels
    // ----------
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            // address and data are taken in either order
            if (AWVALID && awready_reg) begin
                awaddr_reg <= {AWADDR[7:2], 2'b00};
                awready_reg <= 1'b0;
            end
            if (WVALID && wready_reg) begin
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
                wready_reg <= 1'b0;
            end
            if (do_write) begin
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
                bvalid_reg <= 1'b1;
                bresp_reg <= w_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_reg && BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ----------
    // register file, conversion results, flags, interrupt
    // ----------
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl_reg <= `CTRL_RST;
            src_lo_reg <= 16'h0000;
            src_hi_reg <= 16'h0000;
            dst_lo_reg <= 16'h0000;
            dst_hi_reg <= 16'h0000;
            err_code_reg <= 16'h0000;
            status_reg <= `ST_RST;
            mask_reg <= `ST_RST;
            cond_d_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            cond_d_reg <= cond; // edge detect for the pulse form
            if (w_ctrl && wstrb_reg[0]) begin
                ctrl_reg <= wdata_reg[`CTRL_W-1:0];
            end
            // byte lanes of the 16-bit words
            if (w_src_lo && wstrb_reg[0]) begin
                src_lo_reg[7:0] <= wdata_reg[7:0];
            end
            if (w_src_lo && wstrb_reg[1]) begin
                src_lo_reg[15:8] <= wdata_reg[15:8];
            end
            if (w_src_hi && wstrb_reg[0]) begin
                src_hi_reg[7:0] <= wdata_reg[7:0];
            end
            if (w_src_hi && wstrb_reg[1]) begin
                src_hi_reg[15:8] <= wdata_reg[15:8];
            end
            if (w_mask && wstrb_reg[0]) begin
                mask_reg <= wdata_reg[`ST_W-1:0];
            end
            // an error leaves the destination as it was
            if (exec && wr_lo) begin
                dst_lo_reg <= res_lo;
            end
            if (exec && wr_hi) begin
                dst_hi_reg <= res_hi;
            end
            if (exec && err_load) begin
                err_code_reg <= err_val;
            end
            status_reg <= status_next;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    // ----------
    // read data mux
    // ----------
    reg [31:0] rd_mux; // word at the read address
    reg rd_known; // address is mapped

    always @* begin
        rd_mux = 32'h00000000;
        rd_known = 1'b1;
        case ({ARADDR[7:2], 2'b00})
            `OFF_CTRL: rd_mux = {26'h0, ctrl_reg};
            `OFF_SRC_LO: rd_mux = {16'h0000, src_lo_reg};
            `OFF_SRC_HI: rd_mux = {16'h0000, src_hi_reg};
            `OFF_DST_LO: rd_mux = {16'h0000, dst_lo_reg};
            `OFF_DST_HI: rd_mux = {16'h0000, dst_hi_reg};
            `OFF_ERR_CODE: rd_mux = {16'h0000, err_code_reg};
            `OFF_STATUS: rd_mux = {27'h0, status_reg};
            `OFF_MASK: rd_mux = {27'h0, mask_reg};
            default: rd_known = 1'b0; // unmapped reads zero
        endcase
    end

    // ----------
    // axi4-lite read channels
    // ----------
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `RESP_OKAY;
        end else begin
            if (ARVALID && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid_reg && RREADY) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire
